// ==== design/osf_item_store.sv ====
`timescale 1ns/1ps
module osf_item_store
  import osf_pkg::*;
#(
  parameter int WIDTH = OSF_ITEM_W,
  parameter int DEPTH = OSF_DEPTH,
  parameter int AW    = OSF_IDX_W
)
(
  input  wire logic             clk,     // core clock
  input  wire logic             rst_n,   // async reset, active low
  input  wire logic             wr_en,   // store one item
  input  wire logic [AW-1:0]    wr_idx,  // slot written
  input  wire logic [WIDTH-1:0] wr_item, // item written
  input  wire logic [AW-1:0]    rd_idx,  // slot read
  output logic      [WIDTH-1:0] rd_item  // item held at rd_idx
);
  logic [WIDTH-1:0] mem [DEPTH];

  // one flip-flop row per entry
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_entry
      always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
          mem[g] <= '0;
        else if (wr_en && wr_idx == AW'(g))
          mem[g] <= wr_item;
    end
  endgenerate

  // combinational read of the addressed entry
  assign rd_item = mem[rd_idx];
endmodule

// ==== design/osf_link_port.sv ====
`timescale 1ns/1ps
module osf_link_port
  import osf_pkg::*;
(
  input  wire logic       link_clk,   // serial link clock
  input  wire logic       clk,        // core clock
  input  wire logic       rst_n,      // async reset, active low
  input  wire logic       link_req,   // link: one register access
  input  wire logic       link_wr,    // link: access is a write
  input  wire logic [7:0] link_addr,  // link: register offset
  input  wire logic [7:0] link_wdata, // link: write byte
  output logic            link_ack,   // link: access done pulse
  output logic      [7:0] link_rdata, // link: read byte
  output logic            core_req,   // core: access pulse
  output logic            core_wr,    // core: write flag
  output logic      [7:0] core_addr,  // core: offset
  output logic      [7:0] core_wdata, // core: write byte
  input  wire logic       core_resp,  // core: answer pulse
  input  wire logic [7:0] core_rdata  // core: answer byte
);
  logic       lrst_meta, lrst_n;
  logic       req_tgl, req_s1, req_s2, req_s3;
  logic       ack_tgl, ack_s1, ack_s2, ack_s3;
  logic [7:0] resp_hold;

  // link-domain reset, released on the link clock
  always_ff @(posedge link_clk or negedge rst_n)
    if (!rst_n)
    begin
      lrst_meta <= 1'b0;
      lrst_n    <= 1'b0;
    end
    else
    begin
      lrst_meta <= 1'b1;
      lrst_n    <= lrst_meta;
    end

  // link side: hold the access and toggle the request
  always_ff @(posedge link_clk or negedge lrst_n)
    if (!lrst_n)
    begin
      core_wr    <= 1'b0;
      core_addr  <= OSF_RST_BYTE;
      core_wdata <= OSF_RST_BYTE;
      req_tgl    <= 1'b0;
    end
    else if (link_req)
    begin
      core_wr    <= link_wr;
      core_addr  <= link_addr;
      core_wdata <= link_wdata;
      req_tgl    <= ~req_tgl;
    end

  // core side: request toggle synchroniser
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end
    else
    begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end

  // held fields are stable while the toggle travels
  assign core_req = req_s2 ^ req_s3;

  // core side: capture answer and toggle acknowledge
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ack_tgl   <= 1'b0;
      resp_hold <= OSF_RST_BYTE;
    end
    else if (core_resp)
    begin
      ack_tgl   <= ~ack_tgl;
      resp_hold <= core_rdata;
    end

  // link side: acknowledge synchroniser and answer pulse
  always_ff @(posedge link_clk or negedge lrst_n)
    if (!lrst_n)
    begin
      ack_s1     <= 1'b0;
      ack_s2     <= 1'b0;
      ack_s3     <= 1'b0;
      link_ack   <= 1'b0;
      link_rdata <= OSF_RST_BYTE;
    end
    else
    begin
      ack_s1   <= ack_tgl;
      ack_s2   <= ack_s1;
      ack_s3   <= ack_s2;
      link_ack <= ack_s2 ^ ack_s3;
      if (ack_s2 ^ ack_s3)
        link_rdata <= resp_hold;
    end
endmodule

// ==== design/osf_pkg.sv ====
package osf_pkg;
  // queue geometry
  localparam int OSF_DEPTH   = 128;
  localparam int OSF_IDX_W   = 7;
  localparam int OSF_TAG_W   = 5;
  localparam int OSF_VAL_W   = 19;
  localparam int OSF_ITEM_W  = OSF_TAG_W + OSF_VAL_W;

  // register offsets
  localparam logic [7:0] OSF_ADDR_WR_IDX = 8'h04;
  localparam logic [7:0] OSF_ADDR_RD_IDX = 8'h05;
  localparam logic [7:0] OSF_ADDR_LOST   = 8'h06;
  localparam logic [7:0] OSF_ADDR_COUNT  = 8'h07;
  localparam logic [7:0] OSF_ADDR_DATA   = 8'h08;
  localparam logic [7:0] OSF_ADDR_CFG1   = 8'h09;
  localparam logic [7:0] OSF_ADDR_CFG2   = 8'h0a;

  // reset values
  localparam logic [7:0] OSF_RST_BYTE = 8'h00;
  localparam logic [6:0] OSF_RST_IDX  = 7'h00;

  // field positions of the behaviour configuration register
  localparam int OSF_BIT_ROLLOVER = 1;
  localparam int OSF_BIT_AF_TYPE  = 2;
  localparam int OSF_BIT_STAT_CLR = 3;
  localparam int OSF_BIT_FLUSH    = 4;
  localparam int OSF_BIT_TS_EN    = 5;

  // tags, limits and counts
  localparam logic [4:0] OSF_TAG_INVALID   = 5'h1e;
  localparam logic [4:0] OSF_TAG_TIMESTAMP = 5'h1f;
  localparam logic [6:0] OSF_LOST_MAX      = 7'h7f;
  localparam logic [7:0] OSF_FULL_COUNT    = 8'h80;
  localparam int         OSF_TS_SAMPLES    = 8;
  localparam logic [2:0] OSF_TS_LAST       = 3'(OSF_TS_SAMPLES - 1);

  // byte position inside a three-byte item burst
  typedef enum logic [1:0] {OSF_BYTE_HI, OSF_BYTE_MID, OSF_BYTE_LO} osf_byte_t;
endpackage

// ==== design/osf_sample_fifo.sv ====
// Behaviour
// - write index advances per stored item, wraps
// - read index advances per popped item, wraps
// - host may read and rewrite the read index
// - count lost items, saturate at 0x7f
// - lost count clears on a completed pop or a flush
// - available count tracks pushes minus pops
// - three-byte data burst pops one item
// - five-bit tag above left-justified value
// - items stored in slot order each cycle
// - seven-bit watermark in first config register
// - almost-full at 128 minus watermark items
// - enabled almost-full drives active-low interrupt
// - status read clears almost-full flag
// - full queue: rollover discards oldest, else drop
// - level type re-raises flag per sample
// - edge type raises only on fresh entry
// - optional flag clear on data read
// - flush empties queue, bit self-clears
// - 128 entries of 24-bit tagged items
// - empty read returns invalid tag item
// - timestamp item pushed every 8 samples
`timescale 1ns/1ps
module osf_sample_fifo
  import osf_pkg::*;
(
  input  wire logic                 CLK,             // core clock, 20 MHz
  input  wire logic                 RST_N,           // async reset, active low
  input  wire logic                 LINK_CLK,        // serial link clock
  input  wire logic                 LINK_REQ,        // link access request pulse
  input  wire logic                 LINK_WR,         // link access is a write
  input  wire logic [7:0]           LINK_ADDR,       // register offset
  input  wire logic [7:0]           LINK_WDATA,      // write byte
  output logic                      LINK_ACK,        // access done pulse
  output logic      [7:0]           LINK_RDATA,      // read byte
  input  wire logic                 SMP_VALID,       // conversion item strobe
  input  wire logic [OSF_TAG_W-1:0] SMP_TAG,         // source tag of item
  input  wire logic [OSF_VAL_W-1:0] SMP_VALUE,       // left-justified value
  input  wire logic                 SMP_CYCLE_END,   // item closes a sample cycle
  input  wire logic                 STATUS_READ,     // status register read pulse
  input  wire logic                 AF_ENABLE,       // almost-full interrupt mask
  output logic                      A_FULL_FLAG,     // almost-full status flag
  output logic                      DATA_READY_FLAG, // data-ready status flag
  output logic                      INT_N            // interrupt pin, active low
);
  logic                  core_req, core_wr, core_resp;
  logic [7:0]            core_addr, core_wdata, core_rdata, next_rdata;
  logic [6:0]            watermark;
  logic                  ts_en, stat_clr, af_type, rollover;
  logic [6:0]            wr_idx, rd_idx, lost, next_wr_idx, next_rd_idx;
  logic [7:0]            count, next_count, af_level;
  osf_byte_t             byte_phase;
  logic [OSF_ITEM_W-1:0] store_item, head_item, burst_item, push_item;
  logic                  burst_valid;
  logic [OSF_VAL_W-1:0]  sample_cnt;
  logic [2:0]            ts_phase;
  logic                  ts_pending;
  logic                  wr_access, data_read, ri_write, cfg2_write, flush;
  logic                  push_req, push_ok, discard, drop, pop, full, empty;
  logic                  af_now, af_next, af_raise, flag_clear;

  // link access crossing into the core clock
  osf_link_port u_link (
    .link_clk   (LINK_CLK),
    .clk        (CLK),
    .rst_n      (RST_N),
    .link_req   (LINK_REQ),
    .link_wr    (LINK_WR),
    .link_addr  (LINK_ADDR),
    .link_wdata (LINK_WDATA),
    .link_ack   (LINK_ACK),
    .link_rdata (LINK_RDATA),
    .core_req   (core_req),
    .core_wr    (core_wr),
    .core_addr  (core_addr),
    .core_wdata (core_wdata),
    .core_resp  (core_resp),
    .core_rdata (core_rdata)
  );

  // item storage, 128 x 24 flip-flops
  osf_item_store u_store (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr_en   (push_ok),
    .wr_idx  (wr_idx),
    .wr_item (push_item),
    .rd_idx  (rd_idx),
    .rd_item (store_item)
  );

  // access decode
  assign wr_access  = core_req && core_wr;
  assign data_read  = core_req && !core_wr && core_addr == OSF_ADDR_DATA;
  assign ri_write   = wr_access && core_addr == OSF_ADDR_RD_IDX;
  assign cfg2_write = wr_access && core_addr == OSF_ADDR_CFG2;
  assign flush      = cfg2_write && core_wdata[OSF_BIT_FLUSH];

  // push source: conversion item first, pending timestamp in idle cycles
  always_comb
  begin
    push_req = SMP_VALID || ts_pending;
    if (SMP_VALID)
      push_item = {SMP_TAG, SMP_VALUE};
    else
      push_item = {OSF_TAG_TIMESTAMP, sample_cnt};
  end

  // queue occupancy and push/pop decisions
  assign full    = count == OSF_FULL_COUNT;
  assign empty   = count == OSF_RST_BYTE;
  assign pop     = data_read && byte_phase == OSF_BYTE_LO && burst_valid && !empty;
  assign push_ok = push_req && (!full || rollover || pop);
  assign discard = push_req && full && rollover && !pop;
  assign drop    = push_req && full && !rollover && !pop;

  // next indices and count, all from one edge
  always_comb
  begin
    next_wr_idx = wr_idx + {6'h00, push_ok};
    if (ri_write)
      next_rd_idx = core_wdata[6:0];
    else
      next_rd_idx = rd_idx + {6'h00, pop || discard};
    if (ri_write)
      next_count = {1'b0, next_wr_idx - core_wdata[6:0]};
    else
      next_count = count + {7'h00, push_ok} - {7'h00, pop} - {7'h00, discard};
  end

  // queue indices and available count
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      wr_idx <= OSF_RST_IDX;
      rd_idx <= OSF_RST_IDX;
      count  <= OSF_RST_BYTE;
    end
    else if (flush)
    begin
      wr_idx <= OSF_RST_IDX;
      rd_idx <= OSF_RST_IDX;
      count  <= OSF_RST_BYTE;
    end
    else
    begin
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      count  <= next_count;
    end

  // lost-item counter, cleared by a completed pop
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      lost <= OSF_RST_IDX;
    else if (flush || pop)
      lost <= OSF_RST_IDX;
    else if ((drop || discard) && lost != OSF_LOST_MAX)
      lost <= lost + 7'h01;

  // configuration registers; flush bit is never stored
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      watermark <= OSF_RST_IDX;
      ts_en     <= 1'b0;
      stat_clr  <= 1'b0;
      af_type   <= 1'b0;
      rollover  <= 1'b0;
    end
    else
    begin
      if (wr_access && core_addr == OSF_ADDR_CFG1)
        watermark <= core_wdata[6:0];
      if (cfg2_write)
      begin
        ts_en    <= core_wdata[OSF_BIT_TS_EN];
        stat_clr <= core_wdata[OSF_BIT_STAT_CLR];
        af_type  <= core_wdata[OSF_BIT_AF_TYPE];
        rollover <= core_wdata[OSF_BIT_ROLLOVER];
      end
    end

  // byte position in a data burst; any other access restarts it
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      byte_phase <= OSF_BYTE_HI;
    else if (flush || (core_req && !data_read))
      byte_phase <= OSF_BYTE_HI;
    else if (data_read)
      case (byte_phase)
        OSF_BYTE_HI:  byte_phase <= OSF_BYTE_MID;
        OSF_BYTE_MID: byte_phase <= OSF_BYTE_LO;
        OSF_BYTE_LO:  byte_phase <= OSF_BYTE_HI;
        default:      byte_phase <= OSF_BYTE_HI;
      endcase

  // head item, or the invalid marker when nothing is stored
  assign head_item = empty ? {OSF_TAG_INVALID, {OSF_VAL_W{1'b0}}} : store_item;

  // latch the item on the first byte so the burst stays coherent
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      burst_item  <= '0;
      burst_valid <= 1'b0;
    end
    else if (data_read && byte_phase == OSF_BYTE_HI)
    begin
      burst_item  <= head_item;
      burst_valid <= !empty;
    end

  // read multiplexer
  always_comb
  begin
    next_rdata = OSF_RST_BYTE;
    case (core_addr)
      OSF_ADDR_WR_IDX: next_rdata = {1'b0, wr_idx};
      OSF_ADDR_RD_IDX: next_rdata = {1'b0, rd_idx};
      OSF_ADDR_LOST:   next_rdata = {1'b0, lost};
      OSF_ADDR_COUNT:  next_rdata = count;
      OSF_ADDR_DATA:
        case (byte_phase)
          OSF_BYTE_HI:  next_rdata = head_item[23:16];
          OSF_BYTE_MID: next_rdata = burst_item[15:8];
          default:      next_rdata = burst_item[7:0];
        endcase
      OSF_ADDR_CFG1:   next_rdata = {1'b0, watermark};
      OSF_ADDR_CFG2:
      begin
        next_rdata[OSF_BIT_TS_EN]    = ts_en;
        next_rdata[OSF_BIT_STAT_CLR] = stat_clr;
        next_rdata[OSF_BIT_AF_TYPE]  = af_type;
        next_rdata[OSF_BIT_ROLLOVER] = rollover;
      end
      default:         next_rdata = OSF_RST_BYTE;
    endcase
  end

  // answer one cycle after each access
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      core_resp  <= 1'b0;
      core_rdata <= OSF_RST_BYTE;
    end
    else
    begin
      core_resp <= core_req;
      if (core_req)
        core_rdata <= core_wr ? OSF_RST_BYTE : next_rdata;
    end

  // sample cycle counter and timestamp scheduling
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      sample_cnt <= '0;
      ts_phase   <= 3'h0;
      ts_pending <= 1'b0;
    end
    else if (SMP_VALID && SMP_CYCLE_END)
    begin
      sample_cnt <= sample_cnt + 19'h00001;
      ts_phase   <= ts_phase + 3'h1;
      if (ts_en && ts_phase == OSF_TS_LAST)
        ts_pending <= 1'b1;
    end
    else if (!SMP_VALID)
      ts_pending <= 1'b0;

  // almost-full detection
  assign af_level   = OSF_FULL_COUNT - {1'b0, watermark};
  assign af_now     = count >= af_level;
  assign af_next    = next_count >= af_level;
  assign af_raise   = push_ok && af_next && (!af_type || !af_now);
  assign flag_clear = STATUS_READ || (stat_clr && data_read);

  // status flags: a raise in the clearing cycle wins
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      A_FULL_FLAG     <= 1'b0;
      DATA_READY_FLAG <= 1'b0;
    end
    else
    begin
      if (af_raise)
        A_FULL_FLAG <= 1'b1;
      else if (flag_clear)
        A_FULL_FLAG <= 1'b0;
      if (push_ok)
        DATA_READY_FLAG <= 1'b1;
      else if (flag_clear)
        DATA_READY_FLAG <= 1'b0;
    end

  // interrupt pin from the masked almost-full flag
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      INT_N <= 1'b1;
    else
      INT_N <= !(A_FULL_FLAG && AF_ENABLE);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // last byte of a burst over a held item
  sequence s_last_byte;
    data_read && byte_phase == OSF_BYTE_LO && burst_valid && !empty;
  endsequence

  // flush request followed by its cleared state
  sequence s_flush_done;
    flush ##1 (wr_idx == 7'h00 && rd_idx == 7'h00 && count == 8'h00 && lost == 7'h00);
  endsequence

  AST_WR_IDX_STEP: assert property (
    push_ok && !flush |=> wr_idx == 7'($past(wr_idx) + 7'h01))
    else $error("write index did not advance by one");

  AST_RD_IDX_POP: assert property (
    s_last_byte and (!ri_write && !flush) |=> rd_idx == 7'($past(rd_idx) + 7'h01))
    else $error("read index did not advance on completed burst");

  AST_RD_IDX_WRITE: assert property (
    ri_write && !flush |=> rd_idx == $past(core_wdata[6:0]))
    else $error("read index write not taken");

  AST_LOST_SAT: assert property (
    lost == OSF_LOST_MAX && !pop && !flush |=> lost == OSF_LOST_MAX)
    else $error("lost count left saturation");

  AST_LOST_CLEAR: assert property (
    pop |=> lost == 7'h00)
    else $error("lost count not cleared by pop");

  AST_COUNT_UP: assert property (
    push_ok && !pop && !discard && !ri_write && !flush |=> count == $past(count) + 8'h01)
    else $error("available count did not follow push");

  AST_POP_ONLY_LAST: assert property (
    $changed(rd_idx) && !$past(ri_write) && !$past(flush) && !$past(discard)
      |-> $past(byte_phase) == OSF_BYTE_LO)
    else $error("read index moved outside a burst end");

  AST_EMPTY_TAG: assert property (
    data_read && byte_phase == OSF_BYTE_HI && empty |=> core_rdata == 8'hf0)
    else $error("empty read did not return invalid tag");

  AST_DROP: assert property (
    drop && !flush && !ri_write |=> wr_idx == $past(wr_idx) && count == $past(count))
    else $error("dropped item changed the queue");

  AST_EDGE_TYPE: assert property (
    af_type && af_now && !A_FULL_FLAG |=> !A_FULL_FLAG)
    else $error("edge-type flag re-raised without fresh entry");

  AST_LEVEL_TYPE: assert property (
    push_ok && af_next && !af_type |=> A_FULL_FLAG)
    else $error("level-type flag not raised on sample");

  AST_KEEP_FLAG: assert property (
    A_FULL_FLAG && data_read && !stat_clr && !STATUS_READ |=> A_FULL_FLAG)
    else $error("data read cleared flag with option low");

  AST_FLUSH: assert property (
    flush |-> s_flush_done)
    else $error("flush did not empty the queue");

  AST_INT: assert property (
    A_FULL_FLAG && AF_ENABLE |=> !INT_N ##1 (INT_N == !($past(A_FULL_FLAG) && $past(AF_ENABLE))))
    else $error("interrupt pin does not follow masked flag");
endmodule

// ==== testbench/osf_host_model.sv ====
`timescale 1ns/1ps
module osf_host_model
  import osf_pkg::*;
(
  output logic            link_clk,   // link clock, stands still between accesses
  output logic            link_req,   // request pulse
  output logic            link_wr,    // write flag
  output logic      [7:0] link_addr,  // register offset
  output logic      [7:0] link_wdata, // write byte
  input  wire logic       link_ack,   // access done
  input  wire logic [7:0] link_rdata  // read byte
);
  logic run;
  int   lost_acks;

  // idle lines at time zero, clock running through reset
  initial
  begin
    run = 1'b1;
    lost_acks = 0;
    link_clk = 1'b0;
    link_req = 1'b0;
    link_wr = 1'b0;
    link_addr = 8'h00;
    link_wdata = 8'h00;
  end

  // clock halts low once no access is open
  always #80 if (run || link_clk) link_clk = ~link_clk;

  // one access: pulse the request, hold fields until the answer
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    n = 0;
    run = 1'b1;
    repeat (3) @(posedge link_clk);
    link_req   <= 1'b1;
    link_wr    <= wr;
    link_addr  <= a;
    link_wdata <= d;
    do
    begin
      @(posedge link_clk);
      link_req <= 1'b0;
      n++;
    end
    while (link_ack !== 1'b1 && n < 10);
    q = link_rdata;
    if (link_ack !== 1'b1) lost_acks++;
    // released lines show the inverse of their last value
    link_addr  <= ~a;
    link_wdata <= ~d;
    repeat (2) @(posedge link_clk);
    run = 1'b0;
  endtask

  // one item as a three-byte burst of the data register
  task automatic pop_item(output logic [23:0] it);
    access(1'b0, OSF_ADDR_DATA, 8'h00, it[23:16]);
    access(1'b0, OSF_ADDR_DATA, 8'h00, it[15:8]);
    access(1'b0, OSF_ADDR_DATA, 8'h00, it[7:0]);
  endtask

  // lost count first, then the available count, 128 after a loss
  task automatic avail(output logic [7:0] n);
    logic [7:0] l;
    logic [7:0] c;
    access(1'b0, OSF_ADDR_LOST, 8'h00, l);
    access(1'b0, OSF_ADDR_COUNT, 8'h00, c);
    n = (l == 8'h00) ? c : OSF_FULL_COUNT;
  endtask
endmodule

// ==== testbench/osf_sample_fifo_tb_top.sv ====
`timescale 1ns/1ps
module osf_sample_fifo_tb_top
  import osf_pkg::*;
;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 smp_valid = 1'b0;
  logic [OSF_TAG_W-1:0] smp_tag = 5'h00;
  logic [OSF_VAL_W-1:0] smp_value = 19'h00000;
  logic                 smp_end = 1'b0;
  logic                 status_read = 1'b0;
  logic                 af_enable = 1'b0;
  logic                 link_clk, link_req, link_wr, link_ack, a_full, d_ready, int_n;
  logic [7:0]           link_addr, link_wdata, link_rdata, n_avail;
  logic [23:0]          mem [128];
  logic [6:0]           wr = 7'h00, rd = 7'h00, lost = 7'h00;
  logic [7:0]           cnt = 8'h00;
  logic                 ro = 1'b0;
  int                   num_errors = 0, n_compared = 0;

  // core clock
  always #25 clk = ~clk;

  // design and host
  osf_sample_fifo i_dut (.CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .LINK_REQ(link_req),
    .LINK_WR(link_wr), .LINK_ADDR(link_addr), .LINK_WDATA(link_wdata), .LINK_ACK(link_ack),
    .LINK_RDATA(link_rdata), .SMP_VALID(smp_valid), .SMP_TAG(smp_tag), .SMP_VALUE(smp_value),
    .SMP_CYCLE_END(smp_end), .STATUS_READ(status_read), .AF_ENABLE(af_enable),
    .A_FULL_FLAG(a_full), .DATA_READY_FLAG(d_ready), .INT_N(int_n));
  osf_host_model i_host (.link_clk(link_clk), .link_req(link_req), .link_wr(link_wr),
    .link_addr(link_addr), .link_wdata(link_wdata), .link_ack(link_ack),
    .link_rdata(link_rdata));

  // verdict and end of run
  task automatic wrap_up();
    num_errors += i_host.lost_acks;
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // value comparison
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // register read and compare, register write
  task automatic rchk(logic [7:0] a, logic [7:0] e);
    logic [7:0] q;
    i_host.access(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, q});
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    logic [7:0] q;
    i_host.access(1'b1, a, d, q);
  endtask
  task automatic cfg(logic [7:0] v);
    wreg(OSF_ADDR_CFG2, v);
    ro = v[OSF_BIT_ROLLOVER];
  endtask

  // expected state after one offered item
  function automatic void store(logic [23:0] it);
    if (cnt == OSF_FULL_COUNT)
      lost = (lost == OSF_LOST_MAX) ? lost : lost + 7'h01;
    if (cnt == OSF_FULL_COUNT && ro)
      rd = rd + 7'h01;
    if (cnt != OSF_FULL_COUNT || ro)
    begin
      mem[wr] = it;
      wr = wr + 7'h01;
    end
    if (cnt != OSF_FULL_COUNT)
      cnt = cnt + 8'h01;
  endfunction

  // back-to-back random items, then let flags and pin settle
  task automatic push(int n, logic ce);
    logic [23:0] it;
    repeat (n)
    begin
      @(posedge clk);
      it = {5'($urandom_range(29, 1)), 19'($urandom)};
      smp_valid <= 1'b1;
      smp_tag   <= it[23:19];
      smp_value <= it[18:0];
      smp_end   <= ce;
      store(it);
    end
    @(posedge clk);
    smp_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // pop one item and compare with the expected head
  task automatic pop();
    logic [23:0] got;
    logic [23:0] exp;
    i_host.pop_item(got);
    exp = {OSF_TAG_INVALID, 19'h00000};
    if (cnt != 8'h00)
    begin
      exp = mem[rd];
      rd = rd + 7'h01;
      cnt = cnt - 8'h01;
      lost = 7'h00;
    end
    chk("item", exp, got);
  endtask

  // index and count registers
  task automatic regs();
    rchk(OSF_ADDR_WR_IDX, {1'b0, wr});
    rchk(OSF_ADDR_RD_IDX, {1'b0, rd});
    rchk(OSF_ADDR_LOST, {1'b0, lost});
    rchk(OSF_ADDR_COUNT, cnt);
  endtask

  // flush keeping the other settings
  task automatic flush(logic [7:0] k);
    cfg(k | 8'h10);
    wr = 7'h00;
    rd = 7'h00;
    lost = 7'h00;
    cnt = 8'h00;
    rchk(OSF_ADDR_CFG2, k);
    regs();
  endtask

  // flag pins, interrupt and status pulse
  task automatic flags(logic [1:0] e);
    chk("a_full", {23'h0, e[1]}, {23'h0, a_full});
    chk("d_ready", {23'h0, e[0]}, {23'h0, d_ready});
    chk("int_n", {23'h0, ~(e[1] & af_enable)}, {23'h0, int_n});
  endtask
  task automatic setaf(logic v);
    @(posedge clk);
    af_enable <= v;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic sread();
    @(posedge clk);
    status_read <= 1'b1;
    @(posedge clk);
    status_read <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // main sequence
  initial
  begin
    void'($urandom(32'h5fbb));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 4; a < 12; a++)
      rchk(8'(a), (a == 8) ? {OSF_TAG_INVALID, 3'h0} : 8'h00);
    push(5, 1'b0);
    wreg(OSF_ADDR_COUNT, 8'h55);
    regs();
    repeat (6) pop();
    regs();
    wreg(OSF_ADDR_RD_IDX, 8'h02);
    rd = 7'h02;
    cnt = {1'b0, wr - rd};
    regs();
    repeat (3) pop();
    flush(8'h00);
    push(130, 1'b0);
    regs();
    i_host.avail(n_avail);
    chk("avail", 24'h000080, {16'h0000, n_avail});
    push(126, 1'b0);
    regs();
    pop();
    regs();
    cfg(8'h02);
    push(2, 1'b0);
    regs();
    pop();
    flush(8'h00);
    wreg(OSF_ADDR_CFG1, 8'h7d);
    rchk(OSF_ADDR_CFG1, 8'h7d);
    setaf(1'b1);
    sread();
    push(2, 1'b0);
    flags(2'b01);
    push(1, 1'b0);
    flags(2'b11);
    setaf(1'b0);
    flags(2'b11);
    setaf(1'b1);
    sread();
    flags(2'b00);
    push(1, 1'b0);
    flags(2'b11);
    rchk(OSF_ADDR_DATA, mem[rd][23:16]);
    flags(2'b11);
    cfg(8'h08);
    rchk(OSF_ADDR_DATA, mem[rd][23:16]);
    flags(2'b00);
    flush(8'h04);
    push(3, 1'b0);
    flags(2'b11);
    sread();
    push(1, 1'b0);
    flags(2'b01);
    flush(8'h20);
    push(8, 1'b1);
    store({OSF_TAG_TIMESTAMP, 19'd8});
    regs();
    repeat (9) pop();
    cfg(8'h00);
    push(8, 1'b1);
    regs();
    wrap_up();
  end

  // watchdog
  initial
  begin
    #3_000_000;
    num_errors++;
    wrap_up();
  end
endmodule
